// [dr3_rd_burst.sv]
// dr3_rd_burst: read burst side of a DDR3 style memory device.
// assumes commands come from controller logic on the same clock,
// two data beats per clock (rise, fall), AHB-Lite register access.
`timescale 1ns/1ns
module dr3_rd_burst #(
    parameter int DQ_W  = 8,
    parameter int BANKS = 8,
    parameter int DEPTH = 32
) (
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // controller commands, one-cycle pulses
    input  wire logic                      cmd_rd,
    input  wire logic                      cmd_act,
    input  wire logic                      cmd_pre,
    input  wire logic [2:0]                cmd_bank,
    input  wire logic [dr3_pkg::COL_W-1:0] cmd_col,
    input  wire logic                      cmd_a10,
    input  wire logic                      cmd_a12,
    // termination control pin
    input  wire logic                      odt_pin,
    // data and strobe pins
    output logic [DQ_W-1:0]                dq_rise_o,
    output logic [DQ_W-1:0]                dq_fall_o,
    output logic                           dq_oe,
    output logic [1:0]                     dqs_t_o,
    output logic [1:0]                     dqs_c_o,
    output logic                           dqs_oe,
    output logic                           rtt_en_o,
    // AHB-Lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic [31:0]                    hrdata,
    output logic                           hresp
);
    // output engine states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PRE,
        ST_DATA
    } dr3_st_t;

    dr3_st_t           st_reg;    // engine state
    logic [1:0]        cnt_reg;   // data cycles left after this one
    logic [dr3_pkg::COL_W-1:0] col_reg; // current column
    logic [2:0]        beat_reg;  // next beat index
    logic [1:0]        bm_reg;    // burst mode field
    logic [3:0]        cl_reg;    // cas latency
    logic [3:0]        al_reg;    // additive latency
    logic [7:0]        rtp_reg;   // tRTP in cycles
    logic [7:0]        ras_reg;   // tRAS in cycles
    logic [7:0]        rp_reg;    // tRP in cycles
    logic              odt_s1;    // termination pin, first stage
    logic              odt_s2;    // termination pin, synchronised
    logic              wr_pend;   // bus write in data phase
    logic [7:0]        wr_ofs;    // its offset
    logic              req;       // bus transfer accepted
    logic [31:0]       rd_mux;    // read data selection
    logic [BANKS-1:0]  bk_open;   // row open per bank
    logic [BANKS-1:0]  bk_pre;    // precharge running per bank
    logic              rd_bl8;    // this read is eight beats
    logic [1:0]        head_last; // last cycle index of new burst
    logic [DQ_W-1:0]   col_lo;    // column in data width

    dr3_sched_if sif ();

    // latency pipe
    dr3_rd_pipe #(
        .DEPTH (DEPTH)
    ) u_pipe (
        .clk  (clk),
        .rstn (rstn),
        .sif  (sif)
    );

    assign rd_bl8 = (bm_reg == dr3_pkg::BM_BL8) ||
                    ((bm_reg == dr3_pkg::BM_OTF) && cmd_a12);

    assign sif.push = cmd_rd;
    assign sif.slot = 5'({1'b0, al_reg} + {1'b0, cl_reg} - 5'h01);
    assign sif.bl8  = rd_bl8;
    assign sif.col  = cmd_col;

    assign head_last = sif.head_bl8 ? dr3_pkg::BL8_LAST
                                    : dr3_pkg::BC4_LAST;
    assign col_lo    = DQ_W'(col_reg);

    // per bank timers
    genvar g;
    generate
        for (g = 0; g < BANKS; g++)
        begin : g_bank
            dr3_bank_tmr u_tmr (
                .clk      (clk),
                .rstn     (rstn),
                .act      (cmd_act && (cmd_bank == 3'(g))),
                .rd       (cmd_rd && (cmd_bank == 3'(g))),
                .rd_ap    (cmd_a10),
                .pre      (cmd_pre && (cmd_bank == 3'(g))),
                .al       (al_reg),
                .rtp      (rtp_reg),
                .ras      (ras_reg),
                .rp       (rp_reg),
                .open_o   (bk_open[g]),
                .prechg_o (bk_pre[g])
            );
        end
    endgenerate

    // burst engine state
    // a new head cuts short any running burst
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            st_reg   <= ST_IDLE;
            cnt_reg  <= 2'h0;
            col_reg  <= '0;
            beat_reg <= 3'h0;
        end
        else if (sif.head_v)
        begin
            // a new burst starts at once, even before the last beat
            st_reg   <= ST_DATA;
            cnt_reg  <= head_last;
            col_reg  <= sif.head_col;
            beat_reg <= 3'h2;
        end
        else if ((st_reg == ST_DATA) && (cnt_reg != 2'h0))
        begin
            // keep going until the burst is complete
            cnt_reg  <= cnt_reg - 2'h1;
            beat_reg <= beat_reg + 3'h2;
        end
        else if (sif.next_v)
        begin
            st_reg <= ST_PRE;
        end
        else
        begin
            st_reg <= ST_IDLE;
        end
    end

    // data beats, column plus beat index
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            dq_rise_o <= '0;
            dq_fall_o <= '0;
        end
        else if (sif.head_v)
        begin
            dq_rise_o <= DQ_W'(sif.head_col);
            dq_fall_o <= DQ_W'(sif.head_col) + DQ_W'(1);
        end
        else if ((st_reg == ST_DATA) && (cnt_reg != 2'h0))
        begin
            dq_rise_o <= col_lo + DQ_W'(beat_reg);
            dq_fall_o <= col_lo + DQ_W'(beat_reg) + DQ_W'(1);
        end
    end

    assign dq_oe   = (st_reg == ST_DATA);
    assign dqs_oe  = (st_reg != ST_IDLE);
    assign dqs_t_o = {st_reg == ST_DATA, 1'b0};
    assign dqs_c_o = ~dqs_t_o;

    // termination pin synchroniser
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            odt_s1 <= 1'b0;
            odt_s2 <= 1'b0;
        end
        else
        begin
            odt_s1 <= odt_pin;
            odt_s2 <= odt_s1;
        end
    end

    assign rtt_en_o = odt_s2 && !dq_oe;

    // bus: accept address phase
    assign req       = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // read data selection
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            dr3_pkg::CFG_OFS:
            begin
                rd_mux[dr3_pkg::BM_LSB +: 2] = bm_reg;
                rd_mux[dr3_pkg::CL_LSB +: 4] = cl_reg;
                rd_mux[dr3_pkg::AL_LSB +: 4] = al_reg;
            end
            dr3_pkg::TIM_OFS:
            begin
                rd_mux[dr3_pkg::RTP_LSB +: 8] = rtp_reg;
                rd_mux[dr3_pkg::RAS_LSB +: 8] = ras_reg;
                rd_mux[dr3_pkg::RP_LSB +: 8]  = rp_reg;
            end
            dr3_pkg::STAT_OFS:
            begin
                rd_mux[dr3_pkg::OPEN_LSB +: 8] = 8'(bk_open);
                rd_mux[dr3_pkg::PRE_LSB +: 8]  = 8'(bk_pre);
                rd_mux[dr3_pkg::DRV_BIT]       = dqs_oe;
            end
            default:
            begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // bus: read data and pending write
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            hrdata  <= 32'h0000_0000;
            wr_pend <= 1'b0;
            wr_ofs  <= 8'h00;
        end
        else
        begin
            wr_pend <= req && hwrite;
            if (req)
                wr_ofs <= haddr[7:0];
            if (req && !hwrite)
                hrdata <= rd_mux;
        end
    end

    // bus: configuration writes in the data phase
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            bm_reg  <= dr3_pkg::BM_RST;
            cl_reg  <= dr3_pkg::CL_RST;
            al_reg  <= dr3_pkg::AL_RST;
            rtp_reg <= dr3_pkg::RTP_CYC;
            ras_reg <= dr3_pkg::RAS_CYC;
            rp_reg  <= dr3_pkg::RP_CYC;
        end
        else if (wr_pend && (wr_ofs == dr3_pkg::CFG_OFS))
        begin
            bm_reg <= hwdata[dr3_pkg::BM_LSB +: 2];
            cl_reg <= hwdata[dr3_pkg::CL_LSB +: 4];
            al_reg <= hwdata[dr3_pkg::AL_LSB +: 4];
        end
        else if (wr_pend && (wr_ofs == dr3_pkg::TIM_OFS))
        begin
            rtp_reg <= hwdata[dr3_pkg::RTP_LSB +: 8];
            ras_reg <= hwdata[dr3_pkg::RAS_LSB +: 8];
            rp_reg  <= hwdata[dr3_pkg::RP_LSB +: 8];
        end
    end

    a_rl_start: assert property (@(posedge clk) disable iff (!rstn)
        sif.head_v |=> dq_oe && (dq_rise_o == DQ_W'($past(sif.head_col))))
        else $error("burst did not start at read latency");
    a_pre_first: assert property (@(posedge clk) disable iff (!rstn)
        $rose(dq_oe) |-> $past(dqs_oe) && ($past(dqs_t_o) == 2'b00))
        else $error("missing read preamble");
    a_dqs_data: assert property (@(posedge clk) disable iff (!rstn)
        dq_oe |-> dqs_oe && (dqs_t_o == 2'b10) && (dqs_c_o == 2'b01))
        else $error("strobe not toggling with data");
    a_pre_data: assert property (@(posedge clk) disable iff (!rstn)
        (dqs_oe && !dq_oe) |=> dq_oe)
        else $error("preamble not followed by data");
    a_bc4_len: assert property (@(posedge clk) disable iff (!rstn)
        $rose(dq_oe) |-> dq_oe [*2])
        else $error("burst truncated");
    a_release: assert property (@(posedge clk) disable iff (!rstn)
        (dq_oe && (cnt_reg == 2'h0) && !sif.head_v && !sif.next_v)
        |=> !dqs_oe && !dq_oe)
        else $error("outputs not released after burst");
    a_term_off: assert property (@(posedge clk) disable iff (!rstn)
        dq_oe |-> !rtt_en_o)
        else $error("termination on while driving");
    a_chop_len: assert property (@(posedge clk) disable iff (!rstn)
        (cmd_rd && (bm_reg == dr3_pkg::BM_BC4)) |-> !rd_bl8)
        else $error("chop mode gave eight beats");
endmodule : dr3_rd_burst

// [dr3_pkg.sv]
// dr3_pkg: shared constants for the read burst engine.
// assumes a 20 MHz core clock standing in for the command clock.
package dr3_pkg;
    // register byte offsets
    localparam logic [7:0] CFG_OFS  = 8'h00;
    localparam logic [7:0] TIM_OFS  = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    // field positions
    localparam int BM_LSB   = 0;
    localparam int CL_LSB   = 4;
    localparam int AL_LSB   = 8;
    localparam int RTP_LSB  = 0;
    localparam int RAS_LSB  = 8;
    localparam int RP_LSB   = 16;
    localparam int OPEN_LSB = 0;
    localparam int PRE_LSB  = 8;
    localparam int DRV_BIT  = 16;
    // burst mode codes of the mode field
    typedef enum logic [1:0] {
        BM_BL8 = 2'h0,
        BM_OTF = 2'h1,
        BM_BC4 = 2'h2
    } dr3_bm_t;
    // reset values
    localparam logic [1:0] BM_RST = 2'h0;
    localparam logic [3:0] CL_RST = 4'h5;
    localparam logic [3:0] AL_RST = 4'h0;
    // clock period and analog times in picoseconds
    localparam int CLK_PS   = 50000;
    localparam int T_RTP_PS = 7500;
    localparam int T_RAS_PS = 37500;
    localparam int T_RP_PS  = 13750;
    // least times rounded up to whole cycles
    localparam logic [7:0] RTP_CYC = 8'((T_RTP_PS + CLK_PS - 1) / CLK_PS);
    localparam logic [7:0] RAS_CYC = 8'((T_RAS_PS + CLK_PS - 1) / CLK_PS);
    localparam logic [7:0] RP_CYC  = 8'((T_RP_PS + CLK_PS - 1) / CLK_PS);
    // four clocks from the last prefetch to internal precharge
    localparam logic [7:0] PF_MIN_CYC = 8'h04;
    // last cycle index per burst, two beats a cycle
    localparam logic [1:0] BL8_LAST = 2'h3;
    localparam logic [1:0] BC4_LAST = 2'h1;
    // column width
    localparam int COL_W = 10;
endpackage : dr3_pkg

// [dr3_sched_if.sv]
// dr3_sched_if: read scheduling between burst engine and latency pipe.
// assumes both ends on the same clock.
`timescale 1ns/1ns
interface dr3_sched_if;
    logic                       push;     // read accepted
    logic [4:0]                 slot;     // read latency minus one
    logic                       bl8;      // eight beats, else four
    logic [dr3_pkg::COL_W-1:0]  col;      // start column
    logic                       head_v;   // burst starts next cycle
    logic                       head_bl8; // its length
    logic [dr3_pkg::COL_W-1:0]  head_col; // its column
    logic                       next_v;   // burst starts in two cycles
    modport pipe (input push, slot, bl8, col,
                  output head_v, head_bl8, head_col, next_v);
    modport eng (output push, slot, bl8, col,
                 input head_v, head_bl8, head_col, next_v);
endinterface : dr3_sched_if

// [dr3_rd_pipe.sv]
// dr3_rd_pipe: shift line that delays each read by its latency.
// assumes the slot never exceeds DEPTH-1.
`timescale 1ns/1ns
module dr3_rd_pipe #(
    parameter int DEPTH = 32
) (
    input  wire logic  clk,
    input  wire logic  rstn,
    dr3_sched_if.pipe  sif
);
    logic [DEPTH-1:0]          v_reg;  // slot occupied
    logic [DEPTH-1:0]          b_reg;  // slot length
    logic [dr3_pkg::COL_W-1:0] c_reg [DEPTH]; // slot column

    // shift toward the head, then insert the new read
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            v_reg <= '0;
            b_reg <= '0;
        end
        else
        begin
            v_reg <= {1'b0, v_reg[DEPTH-1:1]};
            b_reg <= {1'b0, b_reg[DEPTH-1:1]};
            if (sif.push)
            begin
                v_reg[sif.slot] <= 1'b1;
                b_reg[sif.slot] <= sif.bl8;
            end
        end
    end

    // columns carry no reset
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < DEPTH - 1; i++)
            c_reg[i] <= c_reg[i+1];
        c_reg[DEPTH-1] <= '0;
        if (sif.push)
            c_reg[sif.slot] <= sif.col;
    end

    assign sif.head_v   = v_reg[0];
    assign sif.head_bl8 = b_reg[0];
    assign sif.head_col = c_reg[0];
    assign sif.next_v   = v_reg[1];
endmodule : dr3_rd_pipe

// [dr3_bank_tmr.sv]
// dr3_bank_tmr: one bank's open state and precharge timers.
// assumes commands arrive as one-cycle pulses on the core clock.
`timescale 1ns/1ns
module dr3_bank_tmr (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       act,
    input  wire logic       rd,
    input  wire logic       rd_ap,
    input  wire logic       pre,
    input  wire logic [3:0] al,
    input  wire logic [7:0] rtp,
    input  wire logic [7:0] ras,
    input  wire logic [7:0] rp,
    output logic            open_o,
    output logic            prechg_o
);
    logic [7:0] ras_reg;  // cycles until row active time met
    logic [7:0] rtp_reg;  // cycles until read to precharge met
    logic [7:0] rp_reg;   // cycles of precharge left
    logic       ap_reg;   // auto precharge waiting
    logic [7:0] rtp_eff;  // larger of analog time and four clocks
    logic       fire;     // internal precharge starts

    assign rtp_eff = (rtp > dr3_pkg::PF_MIN_CYC) ? rtp
                                                 : dr3_pkg::PF_MIN_CYC;
    assign fire = ap_reg && (rtp_reg == 8'h00) && (ras_reg == 8'h00);

    // row active lockout counter
    always_ff @(posedge clk)
    begin
        if (!rstn)
            ras_reg <= 8'h00;
        else if (act)
            ras_reg <= ras;
        else if (ras_reg != 8'h00)
            ras_reg <= ras_reg - 8'h01;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            rtp_reg <= 8'h00;
        else if (rd)
            rtp_reg <= 8'(rtp_eff + {4'h0, al} - 8'h01);
        else if (rtp_reg != 8'h00)
            rtp_reg <= rtp_reg - 8'h01;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            ap_reg <= 1'b0;
        else if (rd)
            ap_reg <= rd_ap;
        else if (fire)
            ap_reg <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            rp_reg <= 8'h00;
        else if (pre || fire)
            rp_reg <= rp;
        else if (rp_reg != 8'h00)
            rp_reg <= rp_reg - 8'h01;
    end

    // open row tracking
    always_ff @(posedge clk)
    begin
        if (!rstn)
            open_o <= 1'b0;
        else if (act)
            open_o <= 1'b1;
        else if (pre || fire)
            open_o <= 1'b0;
    end

    assign prechg_o = (rp_reg != 8'h00);

    a_ap_gate: assert property (@(posedge clk) disable iff (!rstn)
        (ap_reg && open_o && !pre && !act &&
         ((rtp_reg != 8'h00) || (ras_reg != 8'h00))) |=> open_o)
        else $error("auto precharge started before limits met");
    a_rp_restart: assert property (
        @(posedge clk) disable iff (!rstn)
        (pre && !act) |=> (rp_reg == $past(rp)) && !open_o)
        else $error("precharge period not restarted");
endmodule : dr3_bank_tmr

// [dr3_ctl_model.sv]
// dr3_ctl_model: controller side that issues device commands.
// assumes send is called right after a rising clock edge.
`timescale 1ns/1ns
module dr3_ctl_model #(
    parameter int RTP = 6, // read to precharge, cycles
    parameter int RP  = 8  // precharge period, cycles
) (
    input  wire logic                 clk,
    output logic                      cmd_rd,
    output logic                      cmd_act,
    output logic                      cmd_pre,
    output logic [2:0]                cmd_bank,
    output logic [dr3_pkg::COL_W-1:0] cmd_col,
    output logic                      cmd_a10,
    output logic                      cmd_a12
);
    int now = 0;   // edges seen
    int rd_ok = 0; // earliest next read
    int cmd_ok [8]; // earliest act or read per bank
    int pre_ok [8]; // earliest precharge per bank
    // idle command lines from time zero
    initial
    begin
        {cmd_rd, cmd_act, cmd_pre, cmd_a10, cmd_a12} = 5'h00;
        cmd_bank = 3'h0;
        cmd_col = '0;
    end
    // edge counter behind every spacing
    always @(posedge clk) now <= now + 1;
    // one command pulse; k: 0 act, 1 read, 2 precharge
    // no writes, bank timers
    task automatic send(input int k, b, c, a10, a12, al);
        int t;
        int e;
        t = (k == 1) ? rd_ok : 0;
        if (k != 2 && cmd_ok[b] > t) t = cmd_ok[b];
        if (k == 2 && pre_ok[b] > t) t = pre_ok[b];
        while (now < t) @(posedge clk);
        e = now;
        cmd_act <= (k == 0);
        cmd_rd <= (k == 1);
        cmd_pre <= (k == 2);
        cmd_bank <= 3'(b);
        cmd_col <= dr3_pkg::COL_W'(c);
        cmd_a10 <= 1'(a10);
        cmd_a12 <= 1'(a12);
        @(posedge clk);
        {cmd_rd, cmd_act, cmd_pre} <= 3'h0;
        // one idle edge, so a following call never rewrites a cleared line
        @(posedge clk);
        if (k == 1) rd_ok = e + 4;
        if (k == 1)
            pre_ok[b] = e + ((al + RTP > 4) ? al + RTP : 4);
        if (k == 1 && a10 != 0) pre_ok[b] = 1 << 30;
        if (k == 1 && a10 != 0) cmd_ok[b] = e + al + RTP + RP;
        if (k == 2) cmd_ok[b] = e + RP;
    endtask : send
endmodule : dr3_ctl_model

// [tb_top.sv]
// tb_top: self-checking bench for the read burst engine.
// assumes zero wait state bus and a per-cycle reference of the pins.
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0;  // core clock
    logic rstn = 1'b0; // reset, active low
    logic odt_pin = 1'b0; // termination control
    logic hsel = 1'b0, hwrite = 1'b0; // bus controls
    logic [1:0] htrans = 2'h0; // transfer kind
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, r; // bus data
    wire logic cmd_rd, cmd_act, cmd_pre, cmd_a10, cmd_a12, hrdy, hresp;
    wire logic [2:0] cmd_bank; // command bank
    wire logic [dr3_pkg::COL_W-1:0] cmd_col; // command column
    wire logic [7:0] dq_r, dq_f; // beats per cycle
    wire logic [1:0] dqs_t, dqs_c; // strobe halves
    wire logic dq_oe, dqs_oe, rtt; // pin enables
    wire logic [31:0] hrdata; // read data
    bit eo [16384]; // expected data cycles
    bit ep [16384]; // expected preamble cycles
    bit [7:0] er [16384], ef [16384]; // expected beats
    int cyc = 0, bm = 0, rl = 5, al = 0, n, j, bad_count = 0, n_compared = 0;
    int md [4] = '{0, 1, 1, 2}; // mode code per pass
    dr3_ctl_model #(.RTP(6), .RP(8)) ctl (.clk(clk), .cmd_rd(cmd_rd),
        .cmd_act(cmd_act), .cmd_pre(cmd_pre), .cmd_bank(cmd_bank),
        .cmd_col(cmd_col), .cmd_a10(cmd_a10), .cmd_a12(cmd_a12));
    dr3_rd_burst dut (.clk(clk), .rstn(rstn), .cmd_rd(cmd_rd),
        .cmd_act(cmd_act), .cmd_pre(cmd_pre), .cmd_bank(cmd_bank),
        .cmd_col(cmd_col), .cmd_a10(cmd_a10), .cmd_a12(cmd_a12),
        .odt_pin(odt_pin), .dq_rise_o(dq_r), .dq_fall_o(dq_f),
        .dq_oe(dq_oe), .dqs_t_o(dqs_t), .dqs_c_o(dqs_c), .dqs_oe(dqs_oe),
        .rtt_en_o(rtt), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp));
    // clock, 50 ns period
    always #25 clk = ~clk;
    // compare and count
    task automatic chk(input string s, input logic [31:0] e, v);
        n_compared++;
        if (v !== e)
        begin
            $display("CHECK FAILED %s exp %h saw %h", s, e, v);
            bad_count++;
        end
    endtask : chk
    // verdict and end of run
    task automatic test_done;
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    // one single word transfer, address then data phase
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        r = hrdata;
        chk("hresp", 32'h0, hresp);
    endtask : bus
    // status read after a wait, open and precharging fields
    task automatic stat(input int w, input logic [31:0] e);
        repeat (w) @(posedge clk);
        bus(1'b0, dr3_pkg::STAT_OFS, 32'h0);
        chk("stat", e, r & 32'hFFFF);
    endtask : stat
    // reference model: fill expected cycles per read, random odt
    always @(posedge clk)
    begin
        if (cmd_rd === 1'b1)
        begin
            n = (bm == 0 || (bm == 1 && cmd_a12 === 1'b1)) ? 4 : 2;
            ep[cyc + rl] = 1'b1;
            for (j = 0; j < n; j++)
            begin
                eo[cyc + rl + 1 + j] = 1'b1;
                er[cyc + rl + 1 + j] = 8'(cmd_col + 2 * j);
                ef[cyc + rl + 1 + j] = 8'(cmd_col + 2 * j + 1);
            end
        end
        if (cyc % 16 == 0) odt_pin <= 1'($urandom % 2);
        cyc <= cyc + 1;
    end
    // pin compare each cycle
    always @(negedge clk)
    begin
        chk("dq_oe", eo[cyc], dq_oe);
        chk("dqs_oe", eo[cyc] | ep[cyc], dqs_oe);
        chk("dqs_c", eo[cyc] ? 32'h1 : 32'h3, dqs_c);
        if (eo[cyc] | ep[cyc]) chk("dqs_t", eo[cyc] ? 2'h2 : 2'h0, dqs_t);
        if (eo[cyc]) chk("dq_r", er[cyc], dq_r);
        if (eo[cyc]) chk("dq_f", ef[cyc], dq_f);
        if (rstn && cyc >= 6 && cyc % 16 >= 4)
            chk("rtt", odt_pin & ~eo[cyc], rtt);
    end
    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        test_done();
    end
    // main sequence
    initial
    begin
        void'($urandom(7014));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        bus(1'b1, dr3_pkg::TIM_OFS, 32'h00081406);
        bus(1'b0, dr3_pkg::TIM_OFS, 32'h0);
        chk("tim", 32'h00081406, r & 32'hFFFFFF);
        bus(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h0, r);
        for (int m = 0; m < 4; m++)
        begin
            bm = md[m];
            al = (m == 3) ? 0 : $urandom % 5;
            rl = al + 5 + $urandom % 7;
            bus(1'b1, dr3_pkg::CFG_OFS, 32'((al << 8) | ((rl - al) << 4) | bm));
            bus(1'b0, dr3_pkg::CFG_OFS, 32'h0);
            chk("cfg", 32'((al << 8) | ((rl - al) << 4) | bm), r & 32'hFFF);
            ctl.send(0, m, 0, 0, 0, al);
            ctl.send(1, m, $urandom % 1024, 0, m & 1, al);
            ctl.send(1, m, $urandom % 1024, 0, m & 1, al);
            ctl.send(2, m, 0, 0, 0, al);
            repeat (50) @(posedge clk);
        end
        // auto precharge held off by tRAS, then tRP
        ctl.send(0, 3, 0, 0, 0, al);
        ctl.send(1, 3, 1020, 1, 0, al);
        stat(12, 32'h0008);
        stat(7, 32'h0800);
        stat(12, 32'h0000);
        // explicit precharge repeated restarts its period
        ctl.send(0, 5, 0, 0, 0, al);
        ctl.send(2, 5, 0, 0, 0, al);
        repeat (3) @(posedge clk);
        ctl.send(2, 5, 0, 0, 0, al);
        stat(5, 32'h2000);
        stat(6, 32'h0000);
        test_done();
    end
endmodule : tb_top
